// ### design/tcc_channel.sv
/*
 * One compare/capture channel of a 16-bit timer: capture trigger
 * selection, compare-hit detection and output waveform shaping, with
 * its registers on a classic Wishbone slave.
 * Assumes the counter value, its tick and its max/zero pulses come from
 * the shared timer counter on clk_i, and the partner comparator's hit
 * is wired in from the other channel of the fixed pair.
 */
`timescale 1ns/1ps
`include "tcc_regs.svh"

module tcc_channel
   import tcc_pkg::*;
#(
   parameter int CNT_W = 16,
   parameter int ADR_W = 4
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [ADR_W-1:0] adr_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   input wire logic we_i,
   input wire logic [3:0] sel_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   output logic ack_o,
   input wire logic [CNT_W-1:0] cnt_value_i,
   input wire logic cnt_tick_i,
   input wire logic cnt_max_i,
   input wire logic cnt_zero_i,
   input wire logic [1:0] cnt_mode_i,
   input wire logic capture_input_pin_i,
   input wire logic partner_match_i,
   output logic match_o,
   output logic capture_event_o,
   output logic timer_output_o
);

   // Bus slave state
   logic ack_q;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;

   // Registers
   logic [15:0] ctl_q;
   logic [15:0] ctl_d;
   logic [CNT_W-1:0] data_q;
   logic [CNT_W-1:0] data_d;
   logic cap_flag_q;
   logic cap_flag_d;

   // Trigger and output state
   logic pin_q;
   logic out_q;
   logic out_d;
   logic cap_event_q;

   // Bus decode
   wire bus_req = cyc_i & stb_i & ~ack_q;
   wire bus_wr = bus_req & we_i;
   wire bus_rd = bus_req & ~we_i;
   wire hit_ctl = (adr_i == `TCC_OFS_CTL);
   wire hit_data = (adr_i == `TCC_OFS_DATA);
   wire hit_stat = (adr_i == `TCC_OFS_STAT);
   wire wr_ctl = bus_wr & hit_ctl;
   wire wr_data = bus_wr & hit_data;
   wire wr_stat = bus_wr & hit_stat;

   // Control fields as currently held
   wire capture_mode = ctl_q[`TCC_CTL_CHANNEL_MODE_SELECT_BIT];
   wire output_polarity = ctl_q[`TCC_CTL_POL_BIT];
   wire [2:0] output_wave_mode = ctl_q[`TCC_CTL_MODE_MSB:`TCC_CTL_MODE_LSB];
   wire soft_output_level = ctl_q[`TCC_CTL_SOFT_BIT];
   wire paired_match_enable = ctl_q[`TCC_CTL_PAIR_BIT];
   wire [1:0] capture_edge_select = ctl_q[`TCC_CTL_EDGE_MSB:`TCC_CTL_EDGE_LSB];
   wire [1:0] capture_source_select = ctl_q[`TCC_CTL_SRC_MSB:`TCC_CTL_SRC_LSB];

   // Control fields as they will be after this cycle's write
   wire new_capture_mode = ctl_d[`TCC_CTL_CHANNEL_MODE_SELECT_BIT];
   wire [1:0] new_edge_select = ctl_d[`TCC_CTL_EDGE_MSB:`TCC_CTL_EDGE_LSB];
   wire [1:0] new_source_select = ctl_d[`TCC_CTL_SRC_MSB:`TCC_CTL_SRC_LSB];

   // Byte-lane merge of a control write, reserved bit kept zero
   always_comb begin
      ctl_d = ctl_q;
      if (wr_ctl) begin
         if (sel_i[0]) begin
            ctl_d[7:0] = dat_i[7:0];
         end
         if (sel_i[1]) begin
            ctl_d[15:8] = dat_i[15:8];
         end
         ctl_d = ctl_d & `TCC_CTL_WMASK;
      end
   end

   // External pin trigger: previous sample against current
   logic pin_fire;

   tcc_trig_edge u_pin_edge (
      .prev_i(pin_q),
      .cur_i(capture_input_pin_i),
      .edge_sel_i(capture_edge_select),
      .fire_o(pin_fire)
   );

   wire ext_src = (capture_source_select == TCC_SRC_EXT);
   wire ext_trig = capture_mode & ext_src & pin_fire;

   // Software trigger: source field moves between soft-low and soft-high
   wire old_sw = (capture_source_select == TCC_SRC_SW_LOW) |
                 (capture_source_select == TCC_SRC_SW_HIGH);
   wire new_sw = (new_source_select == TCC_SRC_SW_LOW) |
                 (new_source_select == TCC_SRC_SW_HIGH);
   logic sw_fire;

   tcc_trig_edge u_sw_edge (
      .prev_i(capture_source_select[0]),
      .cur_i(new_source_select[0]),
      .edge_sel_i(new_edge_select),
      .fire_o(sw_fire)
   );

   wire sw_trig = wr_ctl & old_sw & new_sw & new_capture_mode & sw_fire;

   // Edge select only reaches a trigger in capture mode
   wire capture_trig = ext_trig | sw_trig;

   // Comparator hit on a counter advance
   wire own_hit = ~capture_mode & cnt_tick_i & (cnt_value_i == data_q);

   assign match_o = own_hit;

   // Data register: capture wins over a bus write in the same cycle
   always_comb begin
      data_d = data_q;
      if (capture_trig) begin
         data_d = cnt_value_i;
      end else if (wr_data) begin
         if (sel_i[0]) begin
            data_d[7:0] = dat_i[7:0];
         end
         if (sel_i[1]) begin
            data_d[CNT_W-1:8] = dat_i[CNT_W-1:8];
         end
      end
   end

   // Sticky capture flag, write one to clear, a new capture wins
   wire cap_clear = wr_stat & sel_i[0] & dat_i[`TCC_STAT_CAP_BIT];

   always_comb begin
      cap_flag_d = cap_flag_q;
      if (cap_clear) begin
         cap_flag_d = 1'b0;
      end
      if (capture_trig) begin
         cap_flag_d = 1'b1;
      end
   end

   // Waveform state, held still in capture mode
   logic wave_level;

   tcc_wave_gen u_wave (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .run_i(~capture_mode),
      .mode_i(output_wave_mode),
      .pair_i(paired_match_enable),
      .soft_i(soft_output_level),
      .own_hit_i(own_hit),
      .partner_hit_i(partner_match_i),
      .cnt_max_i(cnt_max_i),
      .cnt_zero_i(cnt_zero_i),
      .cnt_mode_i(cnt_mode_i),
      .level_o(wave_level)
   );

   // Pin level: capture mode drives low, software mode drives the bit as is, other wave modes apply polarity
   always_comb begin
      if (capture_mode) begin
         out_d = 1'b0;
      end else if (output_wave_mode == TCC_WAVE_SOFT) begin
         out_d = soft_output_level;
      end else begin
         out_d = wave_level ^ output_polarity;
      end
   end

   // Read data mux
   always_comb begin
      rdata_d = 32'h0000_0000;
      if (hit_ctl) begin
         rdata_d[15:0] = ctl_q;
      end else if (hit_data) begin
         rdata_d[CNT_W-1:0] = data_q;
      end else if (hit_stat) begin
         rdata_d[`TCC_STAT_OUT_BIT] = out_q;
         rdata_d[`TCC_STAT_CAP_BIT] = cap_flag_q;
      end
   end

   // Bus answer: ack one cycle after the request, dropped the next
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
      end else begin
         ack_q <= bus_req;
         if (bus_rd) begin
            rdata_q <= rdata_d;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctl_q <= `TCC_CTL_RESET;
         data_q <= CNT_W'(`TCC_DATA_RESET);
         cap_flag_q <= 1'b0;
      end else begin
         ctl_q <= ctl_d;
         data_q <= data_d;
         cap_flag_q <= cap_flag_d;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_q <= 1'b0;
         out_q <= 1'b0;
         cap_event_q <= 1'b0;
      end else begin
         pin_q <= capture_input_pin_i;
         out_q <= out_d;
         cap_event_q <= capture_trig;
      end
   end

   assign ack_o = ack_q;
   assign dat_o = rdata_q;
   assign timer_output_o = out_q;
   assign capture_event_o = cap_event_q;

endmodule

// ### design/tcc_regs.svh
/*
 * Register offsets, field positions and reset values of one timer
 * compare/capture channel.
 * Assumes a byte-addressed classic Wishbone slave with 32-bit data.
 */
`ifndef TCC_REGS_SVH
`define TCC_REGS_SVH

`define TCC_OFS_CTL 4'h0
`define TCC_OFS_DATA 4'h4
`define TCC_OFS_STAT 4'h8

`define TCC_CTL_CHANNEL_MODE_SELECT_BIT 0
`define TCC_CTL_POL_BIT 1
`define TCC_CTL_MODE_LSB 2
`define TCC_CTL_MODE_MSB 4
`define TCC_CTL_SOFT_BIT 5
`define TCC_CTL_PAIR_BIT 6
`define TCC_CTL_EDGE_LSB 8
`define TCC_CTL_EDGE_MSB 9
`define TCC_CTL_SRC_LSB 10
`define TCC_CTL_SRC_MSB 11

`define TCC_CTL_RESET 16'h0000
`define TCC_CTL_WMASK 16'hFF7F
`define TCC_DATA_RESET 16'h0000

`define TCC_STAT_OUT_BIT 0
`define TCC_STAT_CAP_BIT 1

`endif

// ### design/tcc_pkg.sv
/*
 * Types shared by the compare/capture channel modules.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package tcc_pkg;

   typedef enum logic [2:0] {
      TCC_WAVE_SOFT = 3'h0,
      TCC_WAVE_RESET = 3'h5,
      TCC_WAVE_TOGGLE_SET = 3'h6,
      TCC_WAVE_RESET_SET = 3'h7
   } tcc_wave_t;

   typedef enum logic [1:0] {
      TCC_SRC_EXT = 2'h0,
      TCC_SRC_SW_LOW = 2'h2,
      TCC_SRC_SW_HIGH = 2'h3
   } tcc_src_t;

   typedef enum logic [1:0] {
      TCC_EDGE_NONE = 2'h0,
      TCC_EDGE_RISE = 2'h1,
      TCC_EDGE_FALL = 2'h2,
      TCC_EDGE_BOTH = 2'h3
   } tcc_edge_t;

   typedef enum logic [1:0] {
      TCC_CNT_UP = 2'h0,
      TCC_CNT_DOWN = 2'h1,
      TCC_CNT_UPDOWN = 2'h2
   } tcc_cnt_t;

endpackage

// ### design/tcc_trig_edge.sv
/*
 * Edge qualifier: decides whether a change from a previous to a current
 * trigger level fires a capture under the selected edge setting.
 * Assumes both levels are already synchronous to the caller's clock.
 */
`timescale 1ns/1ps

module tcc_trig_edge
   import tcc_pkg::*;
(
   input wire logic prev_i,
   input wire logic cur_i,
   input wire logic [1:0] edge_sel_i,
   output logic fire_o
);

   logic rise;
   logic fall;

   assign rise = ~prev_i & cur_i;
   assign fall = prev_i & ~cur_i;

   always_comb begin
      case (edge_sel_i)
         TCC_EDGE_RISE: fire_o = rise;
         TCC_EDGE_FALL: fire_o = fall;
         TCC_EDGE_BOTH: fire_o = rise | fall;
         default: fire_o = 1'b0;
      endcase
   end

endmodule

// ### design/tcc_wave_gen.sv
/*
 * Waveform state of one timer output, kept as an active-true level.
 * Assumes hit and counter events are one-cycle pulses on clk_i.
 */
`timescale 1ns/1ps

module tcc_wave_gen
   import tcc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic run_i,
   input wire logic [2:0] mode_i,
   input wire logic pair_i,
   input wire logic soft_i,
   input wire logic own_hit_i,
   input wire logic partner_hit_i,
   input wire logic cnt_max_i,
   input wire logic cnt_zero_i,
   input wire logic [1:0] cnt_mode_i,
   output logic level_o
);

   logic level_q;
   logic level_d;
   logic restart;
   logic set_ev;

   // Restart is max when counting up or up/down, zero when counting down
   assign restart = (cnt_mode_i == TCC_CNT_DOWN) ? cnt_zero_i : cnt_max_i;
   assign set_ev = pair_i ? partner_hit_i : restart;

   always_comb begin
      level_d = level_q;
      if (run_i) begin
         case (mode_i)
            TCC_WAVE_SOFT: level_d = soft_i;
            TCC_WAVE_RESET_SET: begin
               if (own_hit_i) begin
                  level_d = 1'b0;
               end else if (set_ev) begin
                  level_d = 1'b1;
               end
            end
            TCC_WAVE_TOGGLE_SET: begin
               if (set_ev) begin
                  level_d = 1'b1;
               end else if (own_hit_i) begin
                  level_d = ~level_q;
               end
            end
            TCC_WAVE_RESET: begin
               if (own_hit_i | (pair_i & partner_hit_i)) begin
                  level_d = 1'b0;
               end
            end
            default: level_d = level_q;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         level_q <= 1'b0;
      end else begin
         level_q <= level_d;
      end
   end

   assign level_o = level_q;

endmodule

// ### tb/tcc_pin_model.sv
/*
 * Far-side model of the capture input pin, answering promptly or slowly.
 * Assumes the bench sets the wanted level and speed on clk_i edges.
 */
`timescale 1ns/1ps
module tcc_pin_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic level_i,
   input wire logic slow_i,
   output logic pin_o
);
   logic [2:0] dly_q;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dly_q <= 3'h0;
      end else begin
         dly_q <= {dly_q[1:0], level_i};
      end
   end
   // Slow setting lags the pin by three cycles
   assign pin_o = slow_i ? dly_q[2] : dly_q[0];
endmodule

// ### tb/tcc_monitor.sv
/*
 * Port checks of the compare/capture channel.
 * Assumes one clock clk_i and synchronous active-high rst_i.
 */
`timescale 1ns/1ps
module tcc_monitor #(
   parameter int ADR_W = 4
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [ADR_W-1:0] adr_i,
   input wire logic we_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic ack_o,
   input wire logic [31:0] dat_o,
   input wire logic cnt_tick_i,
   input wire logic cnt_max_i,
   input wire logic cnt_zero_i,
   input wire logic partner_match_i,
   input wire logic capture_input_pin_i,
   input wire logic match_o,
   input wire logic capture_event_o,
   input wire logic timer_output_o
);
   logic ev;
   assign ev = match_o | partner_match_i | cnt_max_i | cnt_zero_i | (cyc_i & stb_i & we_i);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   chk_ack_one_cycle: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   chk_ack_next_edge: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("request not acked next cycle");
   chk_ack_has_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
      else $error("ack without request");
   chk_unmapped_read: assert property (ack_o && $past(!we_i && adr_i == 4'hC) |-> dat_o == 0)
      else $error("unmapped read not zero");
   chk_match_on_tick: assert property (match_o |-> cnt_tick_i)
      else $error("hit without counter tick");
   chk_capture_cause: assert property (capture_event_o |->
      $past(capture_input_pin_i) != $past(capture_input_pin_i, 2)
      || $past(cyc_i && stb_i && we_i) || $past(cyc_i && stb_i && we_i, 2))
      else $error("capture without pin edge or write");
   chk_output_cause: assert property ($changed(timer_output_o) |->
      $past(ev) || $past(ev, 2) || $past(ev, 3))
      else $error("output moved without event");
   chk_reset_quiet: assert property ($fell(rst_i) |-> !ack_o && !capture_event_o
      && !timer_output_o)
      else $error("outputs active after reset");
   cov_capture: cover property (capture_event_o);
   cov_output_rise: cover property ($rose(timer_output_o));
   cov_partner: cover property (partner_match_i ##2 $changed(timer_output_o));
endmodule
bind tcc_channel tcc_monitor #(.ADR_W(ADR_W)) u_mon (.clk_i, .rst_i, .adr_i, .we_i,
   .cyc_i, .stb_i, .ack_o, .dat_o, .cnt_tick_i, .cnt_max_i, .cnt_zero_i, .partner_match_i,
   .capture_input_pin_i, .match_o, .capture_event_o, .timer_output_o);

// ### tb/tcc_channel_tb.sv
/*
 * Self-checking bench of the compare/capture channel.
 * Assumes the pin model and the bound port monitor are compiled first.
 */
`timescale 1ns/1ps
module tcc_channel_tb;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [3:0] adr_i = 4'h0;
   logic [31:0] dat_i = 32'h0000_0000;
   logic [31:0] dat_o;
   logic we_i = 1'b0;
   logic [3:0] sel_i = 4'h0;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic ack_o;
   logic [15:0] cnt_value_i = 16'h1234;
   logic cnt_tick_i = 1'b0;
   logic cnt_max_i = 1'b0;
   logic cnt_zero_i = 1'b0;
   logic [1:0] cnt_mode_i = 2'h0;
   logic capture_input_pin_i;
   logic partner_match_i = 1'b0;
   logic match_o;
   logic capture_event_o;
   logic timer_output_o;
   logic pin_lvl = 1'b0;
   logic slow = 1'b0;
   logic [31:0] q;
   logic [19:0] r;
   int fail_count = 0;
   int samples_checked = 0;
   int cap_seen = 0;
   int cycles = 0;
   // Control, action, count mode, expected capture flag and output
   logic [19:0] rows [41] = '{
      20'h1_0152, 20'h1_0150, 20'h2_0150, 20'h2_0152,
      20'h3_0152, 20'h3_0152, 20'h0_0150, 20'h0_0150,
      20'h8_0100, 20'hD_0102, 20'h9_0100, 20'hE_0100,
      20'hA_0102, 20'hF_0102, 20'hB_0102, 20'hC_0100,
      20'h3_0050, 20'h0_2001, 20'h0_0000, 20'h0_2201,
      20'h0_1401, 20'h0_1410, 20'h0_1C31, 20'h0_1C10,
      20'h0_1C34, 20'h0_1C45, 20'h0_1810, 20'h0_1811,
      20'h0_1810, 20'h0_1839, 20'h0_5C10, 20'h0_5C30,
      20'h0_5C21, 20'h0_5810, 20'h0_5821, 20'h0_5810,
      20'h0_5821, 20'h0_5420, 20'h0_1E01, 20'h0_1E30,
      20'h0_2100};
   tcc_channel u_dut (.clk_i, .rst_i, .adr_i, .dat_i, .dat_o, .we_i, .sel_i, .cyc_i,
      .stb_i, .ack_o, .cnt_value_i, .cnt_tick_i, .cnt_max_i, .cnt_zero_i, .cnt_mode_i,
      .capture_input_pin_i, .partner_match_i, .match_o, .capture_event_o, .timer_output_o);
   tcc_pin_model u_pin (.clk_i, .rst_i, .level_i(pin_lvl), .slow_i(slow),
      .pin_o(capture_input_pin_i));
   task automatic conclude();
      if (fail_count == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
         input logic [3:0] s, output logic [31:0] rd);
      int n;
      n = 0;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      sel_i <= s;
      @(posedge clk_i);
      while (ack_o !== 1'b1 && n < 40) begin
         @(posedge clk_i);
         n++;
      end
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   initial begin
      forever #25 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cycles++;
      if (capture_event_o === 1'b1) cap_seen++;
      if (cycles == 5000) begin
         fail_count++;
         conclude();
      end
   end
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      for (int a = 0; a < 16; a += 4) begin
         wb(1'b0, 4'(a), 32'h0, 4'hF, q);
         chk("reset value", q, 32'h0);
      end
      wb(1'b1, 4'h0, 32'h0000_FFFF, 4'h3, q);
      wb(1'b1, 4'h0, 32'h0000_0000, 4'h1, q);
      wb(1'b0, 4'h0, 32'h0, 4'hF, q);
      chk("control mask", q, 32'h0000_FF00);
      wb(1'b1, 4'hC, 32'h0000_FFFF, 4'hF, q);
      wb(1'b0, 4'hC, 32'h0, 4'hF, q);
      chk("unmapped", q, 32'h0);
      wb(1'b1, 4'h0, 32'h0, 4'h3, q);
      wb(1'b1, 4'h4, 32'h0000_1234, 4'h3, q);
      for (int i = 0; i < 41; i++) begin
         r = rows[i];
         cnt_mode_i <= r[3:2];
         slow <= i[0];
         wb(1'b1, 4'h0, {20'h0_0000, r[19:8]}, 4'h3, q);
         cnt_tick_i <= r[7:4] == 4'h1;
         partner_match_i <= r[7:4] == 4'h2;
         cnt_max_i <= r[7:4] == 4'h3;
         cnt_zero_i <= r[7:4] == 4'h4;
         pin_lvl <= pin_lvl ^ (r[7:4] == 4'h5);
         @(posedge clk_i);
         chk("match", 32'(match_o), 32'(r[7:4] == 4'h1));
         {cnt_tick_i, partner_match_i, cnt_max_i, cnt_zero_i} <= 4'h0;
         repeat (6) @(posedge clk_i);
         wb(1'b0, 4'h8, 32'h0, 4'hF, q);
         chk("status", q, {30'h0, r[1:0]});
         wb(1'b1, 4'h8, 32'h0000_0002, 4'h1, q);
      end
      // Two pin edges on consecutive cycles
      wb(1'b1, 4'h0, 32'h0000_0301, 4'h3, q);
      cap_seen = 0;
      pin_lvl <= ~pin_lvl;
      @(posedge clk_i);
      pin_lvl <= ~pin_lvl;
      cnt_value_i <= 16'h0ABC;
      @(posedge clk_i);
      cnt_value_i <= 16'h0DEF;
      @(posedge clk_i);
      cnt_value_i <= 16'h1234;
      repeat (4) @(posedge clk_i);
      chk("capture count", 32'(cap_seen), 32'h2);
      wb(1'b0, 4'h4, 32'h0, 4'hF, q);
      chk("capture data", q, 32'h0000_0DEF);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wb(1'b0, 4'h4, 32'h0, 4'hF, q);
      chk("data after reset", q, 32'h0);
      conclude();
   end
endmodule
